// ---- wtg_guard.sv ----
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module wtg_guard (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por,
  input wire logic dedicated_timeout_oscillator,
  input wire wtg_pkg::wtg_apb_req_t apb_req,
  output wtg_pkg::wtg_apb_rsp_t apb_rsp,
  output logic chip_rst_req,
  output logic fault_irq,
  output logic warn_irq
);
  import wtg_pkg::*;

  wtg_state_t s_q;
  wtg_state_t s_d;
  logic tick;
  logic setup;
  logic wr;
  logic feed_wr;
  logic key1_wr;
  logic good_feed;
  logic bad_feed;
  logic early_feed;
  logic timeout_evt;
  logic wd_event;
  logic mapped;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic [23:0] clamp_tc(input logic [23:0] v);
    clamp_tc = (v < WTG_TC_MIN) ? WTG_TC_MIN : v;
  endfunction : clamp_tc

  wtg_tick_gen #(
    .DIV(WTG_PRESCALE)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst | por),
    .osc_in(dedicated_timeout_oscillator),
    .tick(tick)
  );

  assign mapped = hit(apb_req.paddr, WTG_OFF_MODE) | hit(apb_req.paddr, WTG_OFF_TC) |
                  hit(apb_req.paddr, WTG_OFF_FEED) | hit(apb_req.paddr, WTG_OFF_TV) |
                  hit(apb_req.paddr, WTG_OFF_WARN) | hit(apb_req.paddr, WTG_OFF_WIN);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign feed_wr = wr & hit(apb_req.paddr, WTG_OFF_FEED);
  assign key1_wr = feed_wr & (apb_req.pwdata[7:0] == WTG_FEED_KEY1);
  assign good_feed = feed_wr & s_q.feed_armed & (apb_req.pwdata[7:0] == WTG_FEED_KEY2);
  // A half-done sequence interrupted by a write to any other register is also a fault
  assign bad_feed = s_q.en & ((feed_wr & ~good_feed & ~key1_wr) | (wr & ~feed_wr & s_q.feed_armed));
  assign early_feed = s_q.en & good_feed & s_q.running & (s_q.cnt > s_q.win);
  assign timeout_evt = s_q.en & s_q.running & tick & (s_q.cnt == 24'h000000);
  assign wd_event = timeout_evt | bad_feed | early_feed;

  always_comb begin
    s_d = s_q;
    s_d.rst_req = 1'b0;
    if (setup) begin
      s_d.rdata = WTG_RDATA_RST;
      if (hit(apb_req.paddr, WTG_OFF_MODE)) begin
        s_d.rdata[WTG_BIT_EN] = s_q.en;
        s_d.rdata[WTG_BIT_RSTMODE] = s_q.rst_mode;
        s_d.rdata[WTG_BIT_EVFLAG] = s_q.ev_flag;
        s_d.rdata[WTG_BIT_WARNFLAG] = s_q.warn_flag;
      end
      if (hit(apb_req.paddr, WTG_OFF_TC)) s_d.rdata[23:0] = s_q.tc;
      if (hit(apb_req.paddr, WTG_OFF_TV)) s_d.rdata[23:0] = s_q.cnt;
      if (hit(apb_req.paddr, WTG_OFF_WARN)) s_d.rdata[23:0] = s_q.warn;
      if (hit(apb_req.paddr, WTG_OFF_WIN)) s_d.rdata[23:0] = s_q.win;
    end
    if (wr & hit(apb_req.paddr, WTG_OFF_MODE)) begin
      if (apb_req.pwdata[WTG_BIT_EN]) s_d.en = 1'b1;
      s_d.rst_mode = apb_req.pwdata[WTG_BIT_RSTMODE];
      if (apb_req.pwdata[WTG_BIT_EVFLAG]) s_d.ev_flag = 1'b0;
      if (apb_req.pwdata[WTG_BIT_WARNFLAG]) s_d.warn_flag = 1'b0;
    end
    if (wr & hit(apb_req.paddr, WTG_OFF_TC)) s_d.tc = clamp_tc(apb_req.pwdata[23:0]);
    if (wr & hit(apb_req.paddr, WTG_OFF_WARN)) s_d.warn = apb_req.pwdata[23:0];
    if (wr & hit(apb_req.paddr, WTG_OFF_WIN)) s_d.win = apb_req.pwdata[23:0];
    if (s_q.running & tick & (s_q.cnt != 24'h000000)) begin
      s_d.cnt = s_q.cnt - 24'h000001;
    end
    if (key1_wr) s_d.feed_armed = 1'b1;
    if (good_feed | wr & ~key1_wr) s_d.feed_armed = 1'b0;
    if (good_feed & s_q.en) begin
      s_d.cnt = s_q.tc;
      s_d.running = 1'b1;
    end
    // Set wins over a same-cycle software clear
    if (s_q.running & (s_q.cnt == s_q.warn)) s_d.warn_flag = 1'b1;
    if (wd_event) begin
      s_d.ev_flag = 1'b1;
      s_d.rst_req = s_q.rst_mode;
      s_d.en = 1'b0;
      s_d.running = 1'b0;
      s_d.feed_armed = 1'b0;
    end
  end

  // The event flag must outlive the reset the watchdog itself asked for
  always_ff @(posedge clk_sys) begin
    if (rst | por) begin
      s_q <= WTG_STATE_RST;
      if (!por) s_q.ev_flag <= s_q.ev_flag;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;
  assign apb_rsp.prdata = s_q.rdata;
  assign chip_rst_req = s_q.rst_req;
  assign fault_irq = s_q.ev_flag & ~s_q.rst_mode;
  assign warn_irq = s_q.warn_flag;

  chk_timeout_reset: assert property (@(posedge clk_sys) disable iff (rst | por)
    timeout_evt & s_q.rst_mode |=> chip_rst_req ##1 !chip_rst_req)
    else $error("expiry did not give a single reset request");
  chk_rst_pulse_src: assert property (@(posedge clk_sys) disable iff (rst | por)
    chip_rst_req |-> $past(wd_event) && $past(s_q.rst_mode))
    else $error("reset request without a watchdog event");
  chk_window_early: assert property (@(posedge clk_sys) disable iff (rst | por)
    good_feed & s_q.en & s_q.running & (s_q.cnt > s_q.win) |=> s_q.ev_flag && !s_q.en)
    else $error("early reload not taken as a fault");
  // A reload inside the window must keep the guard running
  chk_window_ok: assert property (@(posedge clk_sys) disable iff (rst | por)
    good_feed & s_q.en & s_q.running & (s_q.cnt <= s_q.win) & !timeout_evt |=> s_q.running)
    else $error("reload inside the window taken as a fault");
  chk_warn_raise: assert property (@(posedge clk_sys) disable iff (rst | por)
    s_q.running & (s_q.cnt == s_q.warn) |=> warn_irq)
    else $error("warning not raised at programmed count");
  chk_warn_hold: assert property (@(posedge clk_sys) disable iff (rst | por)
    warn_irq & !(wr & hit(apb_req.paddr, WTG_OFF_MODE) & apb_req.pwdata[WTG_BIT_WARNFLAG]) |=> warn_irq)
    else $error("warning dropped without a clear");
  chk_warn_clear: assert property (@(posedge clk_sys) disable iff (rst | por)
    wr & hit(apb_req.paddr, WTG_OFF_MODE) & apb_req.pwdata[WTG_BIT_WARNFLAG] &
    !(s_q.running & (s_q.cnt == s_q.warn)) |=> !warn_irq)
    else $error("warning flag not cleared by software");
  chk_enable_sticky: assert property (@(posedge clk_sys) disable iff (rst | por)
    s_q.en & !wd_event |=> s_q.en)
    else $error("enable cleared without a watchdog event");
  chk_enable_set: assert property (@(posedge clk_sys) disable iff (rst | por)
    wr & hit(apb_req.paddr, WTG_OFF_MODE) & apb_req.pwdata[WTG_BIT_EN] & !wd_event |=> s_q.en)
    else $error("enable write did not take");
  chk_event_disable: assert property (@(posedge clk_sys) disable iff (rst | por)
    wd_event |=> !s_q.en && !s_q.running)
    else $error("watchdog event left the guard enabled");
  chk_bad_feed: assert property (@(posedge clk_sys) disable iff (rst | por)
    bad_feed |=> !s_q.en ##0 (chip_rst_req == $past(s_q.rst_mode)) ##0 s_q.ev_flag)
    else $error("wrong feed sequence not handled");
  chk_feed_arm: assert property (@(posedge clk_sys) disable iff (rst | por)
    key1_wr & !timeout_evt |=> s_q.feed_armed)
    else $error("first feed key did not arm the sequence");
  // In interrupt mode an event must never reach the chip reset line
  chk_irq_mode: assert property (@(posedge clk_sys) disable iff (rst | por)
    wd_event & !s_q.rst_mode & !(wr & hit(apb_req.paddr, WTG_OFF_MODE)) |=> fault_irq && !chip_rst_req)
    else $error("interrupt mode event handled as reset");
  chk_rst_mode_wr: assert property (@(posedge clk_sys) disable iff (rst | por)
    wr & hit(apb_req.paddr, WTG_OFF_MODE) |=> s_q.rst_mode == $past(apb_req.pwdata[WTG_BIT_RSTMODE]))
    else $error("response mode write did not take");
  chk_flag_hold: assert property (@(posedge clk_sys) disable iff (por)
    s_q.ev_flag & rst |=> s_q.ev_flag)
    else $error("event flag lost over chip reset");
  chk_flag_set: assert property (@(posedge clk_sys) disable iff (rst | por)
    wd_event |=> s_q.ev_flag)
    else $error("watchdog event not recorded");
  chk_evflag_clear: assert property (@(posedge clk_sys) disable iff (rst | por)
    wr & hit(apb_req.paddr, WTG_OFF_MODE) & apb_req.pwdata[WTG_BIT_EVFLAG] & !wd_event |=> !s_q.ev_flag)
    else $error("event flag not cleared by software");
  chk_por_clear: assert property (@(posedge clk_sys)
    por |=> !s_q.ev_flag && !fault_irq)
    else $error("power-on reset kept the event flag");
  chk_count_step: assert property (@(posedge clk_sys) disable iff (rst | por)
    s_q.running & tick & (s_q.cnt != 24'h000000) & !good_feed & !wd_event |=> s_q.cnt == $past(s_q.cnt) - 24'h000001)
    else $error("counter did not step by one");
  chk_reload_value: assert property (@(posedge clk_sys) disable iff (rst | por)
    good_feed & s_q.en & !wd_event |=> s_q.cnt == $past(s_q.tc) && s_q.running)
    else $error("reload did not restore time-out");
  chk_cnt_frozen: assert property (@(posedge clk_sys) disable iff (rst | por)
    !s_q.running & !(good_feed & s_q.en) |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved while stopped");
  chk_tc_floor: assert property (@(posedge clk_sys) disable iff (rst | por)
    s_q.tc >= WTG_TC_MIN)
    else $error("time-out below the lower bound");
  chk_tc_clamp: assert property (@(posedge clk_sys) disable iff (rst | por)
    wr & hit(apb_req.paddr, WTG_OFF_TC) & (apb_req.pwdata[23:0] < WTG_TC_MIN) |=> s_q.tc == WTG_TC_MIN)
    else $error("short time-out not raised to the floor");
  chk_tick_gap: assert property (@(posedge clk_sys) disable iff (rst | por)
    tick |=> !tick [*5])
    else $error("oscillator crossing produced ticks too fast");
  // Read data is a snapshot taken in the setup cycle
  chk_read_capture: assert property (@(posedge clk_sys) disable iff (rst | por)
    setup & !apb_req.pwrite & hit(apb_req.paddr, WTG_OFF_TC) |=> apb_rsp.prdata == {8'h00, $past(s_q.tc)})
    else $error("time-out read did not return the stored value");
  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst | por)
    setup & !mapped |=> apb_rsp.prdata == WTG_RDATA_RST && apb_rsp.pslverr)
    else $error("unmapped access not refused");

  cov_feed_ok: cover property (@(posedge clk_sys) disable iff (rst | por) good_feed & s_q.en & !wd_event);
  cov_timeout: cover property (@(posedge clk_sys) disable iff (rst | por) timeout_evt);
  cov_bad_feed: cover property (@(posedge clk_sys) disable iff (rst | por) bad_feed);
  cov_warn: cover property (@(posedge clk_sys) disable iff (rst | por) warn_irq & !$past(warn_irq));
  cov_early_feed: cover property (@(posedge clk_sys) disable iff (rst | por) early_feed);
endmodule : wtg_guard

// ---- wtg_guard_tb.sv ----
`timescale 1ns/1ps
module wtg_guard_tb;
  import wtg_pkg::*;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic osc = 1'b0;
  wtg_apb_req_t req = '0;
  wtg_apb_rsp_t rsp;
  logic chip_rst_req, fault_irq, warn_irq;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_rst = 0;
  int k;
  logic [32:0] expq[$];
  logic [32:0] e;
  logic [15:0] lfsr = 16'hde73;

  wtg_guard dut (.clk_sys(clk_sys), .rst(rst), .por(por), .dedicated_timeout_oscillator(osc),
    .apb_req(req), .apb_rsp(rsp), .chip_rst_req(chip_rst_req), .fault_irq(fault_irq), .warn_irq(warn_irq));

  initial forever #5 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Oscillator runs free at 1/8 of the bus clock; a limit on cycles cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc % 4 == 0) osc <= ~osc;
    if (chip_rst_req === 1'b1) n_rst++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Read results are taken at the access edge and matched against the oldest note
  always @(posedge clk_sys) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      e = expq.pop_front();
      `CHK({rsp.pslverr, rsp.prdata}, e)
    end
  end

  // Waits for pready without a limit of its own; an idle edge after release keeps one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    if (!w) expq.push_back(x);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin @(posedge clk_sys); end while (rsp.pready !== 1'b1);
    req <= '0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, '0, {1'b0, d});
  endtask : rd

  task automatic feed();
    wr(WTG_OFF_FEED, {24'h0, WTG_FEED_KEY1});
    wr(WTG_OFF_FEED, {24'h0, WTG_FEED_KEY2});
  endtask : feed

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk_sys);
    rd(WTG_OFF_MODE, 32'h0);
    rd(WTG_OFF_TC, {8'h0, WTG_TC_RST});
    rd(WTG_OFF_WARN, {8'h0, WTG_WARN_RST});
    rd(WTG_OFF_WIN, {8'h0, WTG_WIN_RST});
    apb(1'b0, 8'h18, '0, {1'b1, 32'h0});
    wr(WTG_OFF_TC, 32'h10);
    rd(WTG_OFF_TC, 32'h100);
    lfsr = lfsr_next(lfsr);
    wr(WTG_OFF_WARN, {16'h0, lfsr});
    rd(WTG_OFF_WARN, {16'h0, lfsr});
    wr(WTG_OFF_WARN, 32'h80);
    wr(WTG_OFF_MODE, 32'h1);
    wr(WTG_OFF_MODE, 32'h0);
    rd(WTG_OFF_MODE, 32'h1);
    feed();
    for (k = 0; k < 12000 && warn_irq !== 1'b1; k++) @(posedge clk_sys);
    `CHK(k > 4056 && k < 4136, 1'b1)
    for (k = 0; k < 12000 && fault_irq !== 1'b1; k++) @(posedge clk_sys);
    `CHK(k > 4088 && k < 4168, 1'b1)
    `CHK(n_rst, 0)
    rd(WTG_OFF_MODE, 32'hc);
    rd(WTG_OFF_TV, 32'h0);
    rd(WTG_OFF_FEED, 32'h0);
    wr(WTG_OFF_MODE, 32'hc);
    rd(WTG_OFF_MODE, 32'h0);
    // Two kinds of broken feed: a foreign write after the first key, and a wrong second key
    for (int i = 0; i < 2; i++) begin
      wr(WTG_OFF_MODE, 32'h1);
      wr(WTG_OFF_FEED, {24'h0, WTG_FEED_KEY1});
      if (i == 0) wr(WTG_OFF_TC, 32'h100);
      else wr(WTG_OFF_FEED, 32'h12);
      repeat (2) @(posedge clk_sys);
      `CHK(fault_irq, 1'b1)
      wr(WTG_OFF_MODE, 32'h4);
    end
    wr(WTG_OFF_MODE, 32'h3);
    feed();
    wr(WTG_OFF_WIN, 32'h80);
    feed();
    repeat (3) @(posedge clk_sys);
    `CHK(n_rst, 1)
    `CHK(fault_irq, 1'b0)
    wr(WTG_OFF_TV, 32'h55);
    rd(WTG_OFF_TV, 32'h100);
    wr(WTG_OFF_WIN, {8'h0, WTG_WIN_RST});
    wr(WTG_OFF_MODE, 32'h3);
    feed();
    for (k = 0; k < 12000 && n_rst < 2; k++) @(posedge clk_sys);
    `CHK(k > 8184 && k < 8264, 1'b1)
    repeat (3) @(posedge clk_sys);
    `CHK(n_rst, 2)
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(WTG_OFF_MODE, 32'h4);
    `CHK(fault_irq, 1'b1)
    por <= 1'b1;
    repeat (2) @(posedge clk_sys);
    por <= 1'b0;
    @(posedge clk_sys);
    rd(WTG_OFF_MODE, 32'h0);
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : wtg_guard_tb

// ---- wtg_pkg.sv ----
package wtg_pkg;
  localparam int unsigned WTG_CNT_W = 24;
  localparam int unsigned WTG_ADDR_W = 8;
  localparam int unsigned WTG_PRESCALE = 4;
  localparam logic [7:0] WTG_OFF_MODE = 8'h00;
  localparam logic [7:0] WTG_OFF_TC = 8'h04;
  localparam logic [7:0] WTG_OFF_FEED = 8'h08;
  localparam logic [7:0] WTG_OFF_TV = 8'h0c;
  localparam logic [7:0] WTG_OFF_WARN = 8'h10;
  localparam logic [7:0] WTG_OFF_WIN = 8'h14;
  localparam int unsigned WTG_BIT_EN = 0;
  localparam int unsigned WTG_BIT_RSTMODE = 1;
  localparam int unsigned WTG_BIT_EVFLAG = 2;
  localparam int unsigned WTG_BIT_WARNFLAG = 3;
  localparam logic [7:0] WTG_FEED_KEY1 = 8'haa;
  localparam logic [7:0] WTG_FEED_KEY2 = 8'h55;
  localparam logic [23:0] WTG_TC_MIN = 24'h000100;
  localparam logic [23:0] WTG_TC_RST = 24'hffffff;
  localparam logic [23:0] WTG_WARN_RST = 24'h000000;
  localparam logic [23:0] WTG_WIN_RST = 24'hffffff;
  localparam logic [31:0] WTG_RDATA_RST = 32'h00000000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wtg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wtg_apb_rsp_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic [1:0] div;
    logic tick;
  } wtg_tick_state_t;

  typedef struct packed {
    logic en;
    logic rst_mode;
    logic running;
    logic feed_armed;
    logic warn_flag;
    logic ev_flag;
    logic rst_req;
    logic [23:0] tc;
    logic [23:0] cnt;
    logic [23:0] warn;
    logic [23:0] win;
    logic [31:0] rdata;
  } wtg_state_t;

  localparam wtg_tick_state_t WTG_TICK_RST = '{sync1: 1'b0, sync2: 1'b0, last: 1'b0, div: 2'h0, tick: 1'b0};
  localparam wtg_state_t WTG_STATE_RST = '{en: 1'b0, rst_mode: 1'b0, running: 1'b0, feed_armed: 1'b0,
    warn_flag: 1'b0, ev_flag: 1'b0, rst_req: 1'b0, tc: WTG_TC_RST, cnt: WTG_TC_RST,
    warn: WTG_WARN_RST, win: WTG_WIN_RST, rdata: WTG_RDATA_RST};
endpackage : wtg_pkg

// ---- wtg_tick_gen.sv ----
`timescale 1ns/1ps
module wtg_tick_gen #(
  parameter int unsigned DIV = wtg_pkg::WTG_PRESCALE
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic osc_in,
  output logic tick
);
  import wtg_pkg::*;

  wtg_tick_state_t s_q;
  wtg_tick_state_t s_d;
  logic rise;

  // The two-bit divider below serves a ratio of four only
  if (DIV != 4) begin : g_div_check
    $error("wtg_tick_gen: divider is built for four only");
  end

  // Only the second stage and its delayed copy in last are ever looked at
  assign rise = s_q.sync2 & ~s_q.last;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = osc_in;
    s_d.sync2 = s_q.sync1;
    s_d.last = s_q.sync2;
    s_d.tick = 1'b0;
    if (rise) begin
      s_d.div = s_q.div + 2'h1;
      s_d.tick = (s_q.div == 2'h3);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= WTG_TICK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  chk_tick_single_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    tick |=> !tick [*3]) else $error("prescaler ticks closer than the division allows");
endmodule : wtg_tick_gen
